// ### sxo_defines.svh
// Constants for the off-line/self-test command interpreter
`ifndef SXO_DEFINES_SVH
`define SXO_DEFINES_SVH
// Register byte offsets
`define SXO_OFF_FEATURES   8'h00
`define SXO_OFF_SECCNT     8'h04
`define SXO_OFF_SUBCMD     8'h08
`define SXO_OFF_SIGLO      8'h0C
`define SXO_OFF_SIGHI      8'h10
`define SXO_OFF_DRVSEL     8'h14
`define SXO_OFF_COMMAND    8'h18
`define SXO_OFF_ERROR      8'h1C
`define SXO_OFF_STATE      8'h20
`define SXO_OFF_CTRL       8'h24
`define SXO_OFF_RESULT     8'h28
// Command and feature codes
`define SXO_CMD_SMART      8'hB0
`define SXO_FEAT_EXEC      8'hD4
`define SXO_FEAT_DISABLE   8'hD9
`define SXO_FEAT_ENABLE    8'hD8
`define SXO_CMD_SLEEP      8'hE6
`define SXO_CMD_STBY_IMM   8'hE0
`define SXO_CMD_IDLE_IMM   8'hE1
// Signatures
`define SXO_KEY_LO         8'h4F
`define SXO_KEY_HI         8'hC2
`define SXO_FAIL_LO        8'hF4
`define SXO_FAIL_HI        8'h2C
// Subcommands
`define SXO_SUB_COLLECT    8'h00
`define SXO_SUB_SHORT      8'h01
`define SXO_SUB_EXTEND     8'h02
`define SXO_SUB_ABORT      8'h7F
`define SXO_SUB_CAP_SHORT  8'h81
`define SXO_SUB_CAP_EXTEND 8'h82
// Error and status bit positions
`define SXO_ERR_ABRT       2
`define SXO_ERR_IDNF       4
`define SXO_ST_ERR         0
`define SXO_ST_DF          5
`define SXO_ST_DRDY        6
`define SXO_ST_BSY         7
// Control register bits
`define SXO_CTL_SUPPORTED  0
`define SXO_CTL_ENABLED    1
// Timing
`define SXO_CLK_MHZ        40
`define SXO_SERVICE_MS     2000
`define SXO_SERVICE_CYC    (`SXO_SERVICE_MS * 1000 * `SXO_CLK_MHZ)
`define SXO_AXI_OKAY       2'b00
`define SXO_AXI_SLVERR     2'b10
`endif

// ### sxo_engine_model.sv
// Behavioural routine engine facing the interpreter
`timescale 1ns/1ps
`default_nettype none
module sxo_engine_model #(
   parameter int DONE_CYC = 20
) (
   input  wire logic       aclk,         // Clock
   input  wire logic       aresetn,      // Sync reset, low
   input  wire logic       routine_run,  // Run request
   input  wire logic [7:0] routine_sel,  // Subcommand
   input  wire logic       fail_mode,    // Bench orders a failing test
   output logic            routine_done, // Finished
   output logic            routine_fail, // Test failed
   output logic            idnf_event,   // Sector ID missing
   output logic            fault_event   // Device fault
);
   int cnt;
   // Captive tests end; off-line ones run until stopped
   always @(posedge aclk) begin
      if (!aresetn || !routine_run) begin
         cnt <= 0;
         routine_done <= 1'b0;
         routine_fail <= 1'b0;
         idnf_event <= 1'b0;
         fault_event <= 1'b0;
      end else if (routine_sel[7] && cnt < DONE_CYC) begin
         cnt <= cnt + 1;
      end else if (routine_sel[7]) begin
         routine_done <= 1'b1;
         routine_fail <= fail_mode;
         idnf_event <= fail_mode;
         fault_event <= fail_mode;
      end
   end
endmodule : sxo_engine_model
`default_nettype wire

// ### sxo_exec.sv
// Device-side interpreter for the off-line immediate/self-test command
`timescale 1ns/1ps
`default_nettype none
`include "sxo_defines.svh"

// Overview of operation
// - Unsupported, disabled or bad inputs give command aborted.
// - Captive self-test failure aborts, returns F4h low, 2Ch high.
// - Error completion sets IDNF when the sector ID is missing.
// - ABRT for unsupported, disabled, bad inputs or captive failure.
// - Other captive errors return 4Fh low and C2h high.
// - Off-line subcommand errors leave signature bytes undefined.
// - Error completion clears BSY, DRQ; sets DRDY, ERR; DF only on a device fault.
// - Values 0, 1, 2 start collection, short, extended off-line.
// - Value 127 aborts an off-line self-test.
// - Values 129, 130 run short and extended tests captive.
// - Off-line mode completes the command before the routine.
// - Off-line routine keeps BSY zero and DRDY one.
// - Other commands suspend the routine, served within two seconds; here the routine keeps running while BSY is set.
// - SLEEP aborts a running self-test, then sleeps.
// - SMART disable suspends; next enable may resume.
// - New execute command aborts the routine, runs the new one.
// - Standby/idle immediate suspend; power-save exit resumes.
// - No automatic power state change during a routine.
// - Off-line self-test failure may stop and record outcome.
// - DEV bit reflects the selected device on errors.
// - Captive mode holds BSY, stores result, then completes.
// - Captive pass leaves 4Fh low and C2h high.
// - Command code B0h with features D4h.
module sxo_exec #(
   parameter int unsigned SERVICE_CYC = `SXO_SERVICE_CYC
) (
   input  wire logic        aclk,          // 40 MHz clock
   input  wire logic        aresetn,       // Synchronous reset, low
   input  wire logic [7:0]  s_axi_awaddr,  // Write address
   input  wire logic        s_axi_awvalid, // Write address valid
   output logic             s_axi_awready, // Write address ready
   input  wire logic [31:0] s_axi_wdata,   // Write data
   input  wire logic [3:0]  s_axi_wstrb,   // Write strobes
   input  wire logic        s_axi_wvalid,  // Write data valid
   output logic             s_axi_wready,  // Write data ready
   output logic [1:0]       s_axi_bresp,   // Write response
   output logic             s_axi_bvalid,  // Write response valid
   input  wire logic        s_axi_bready,  // Write response ready
   input  wire logic [7:0]  s_axi_araddr,  // Read address
   input  wire logic        s_axi_arvalid, // Read address valid
   output logic             s_axi_arready, // Read address ready
   output logic [31:0]      s_axi_rdata,   // Read data
   output logic [1:0]       s_axi_rresp,   // Read response
   output logic             s_axi_rvalid,  // Read data valid
   input  wire logic        s_axi_rready,  // Read data ready
   input  wire logic        routine_done,  // Routine engine finished
   input  wire logic        routine_fail,  // Self-test detected failure
   input  wire logic        idnf_event,    // Data sector ID not found
   input  wire logic        fault_event,   // Device fault seen
   output logic             routine_run,   // Engine may run routine
   output logic [7:0]       routine_sel,   // Active subcommand
   output logic             cmd_pending,   // Non-routine command to serve
   output logic             standby_hold   // Blocks automatic standby
);

   sxo_pkg::sxo_state_t s_r;
   sxo_pkg::sxo_state_t s_nxt;

   // Engine inputs, two-flop synced
   logic [3:0] ev_m_r;
   logic [3:0] ev_r;
   // Service timer while a command waits
   logic [31:0] svc_cnt_r;
   logic [31:0] svc_cnt_nxt;

   logic       wr_fire;
   logic       rd_fire;
   logic [7:0] cmd_code;
   logic       is_smart;
   logic       key_ok;
   logic       sub_valid;
   logic       sub_captive;
   logic       sub_offline;
   logic       run_selftest;

   // Write fires once address and data are both held
   assign wr_fire  = s_r.awv && s_r.wv && !s_r.bvalid;
   assign rd_fire  = s_axi_arvalid && s_r.arready;
   assign cmd_code = s_r.wdata[7:0];
   assign is_smart = cmd_code == `SXO_CMD_SMART;
   assign key_ok   = s_r.sig_lo == `SXO_KEY_LO
                     && s_r.sig_hi == `SXO_KEY_HI;
   assign sub_captive = s_r.subcmd == `SXO_SUB_CAP_SHORT
                        || s_r.subcmd == `SXO_SUB_CAP_EXTEND;
   assign sub_offline = s_r.subcmd == `SXO_SUB_COLLECT
                        || s_r.subcmd == `SXO_SUB_SHORT
                        || s_r.subcmd == `SXO_SUB_EXTEND;
   // Reserved and vendor codes all fall outside this set
   assign sub_valid = sub_captive || sub_offline
                      || s_r.subcmd == `SXO_SUB_ABORT;
   assign run_selftest = s_r.routine != `SXO_SUB_COLLECT;

   // Two-flop synchroniser for the engine event inputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ev_m_r <= 4'h0;
         ev_r   <= 4'h0;
      end else begin
         ev_m_r <= {fault_event, idnf_event, routine_fail, routine_done};
         ev_r   <= ev_m_r;
      end
   end

   // Next-state logic: bus slave, command decode, routine control
   always_comb begin
      s_nxt       = s_r;
      svc_cnt_nxt = svc_cnt_r;
      s_nxt.stop_req = 1'b0;

      // Write channels accepted independently, in either order
      if (s_axi_awvalid && !s_r.awv) begin
         s_nxt.awv    = 1'b1;
         s_nxt.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s_r.wv) begin
         s_nxt.wv    = 1'b1;
         s_nxt.wdata = s_axi_wdata;
         s_nxt.wstrb = s_axi_wstrb;
      end
      if (s_r.bvalid && s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
      end

      // Captive routine end: store result then complete
      if (s_r.run == sxo_pkg::SXO_CAPTIVE && (ev_r[0] || ev_r[1])) begin
         s_nxt.st_status = {6'h00, ev_r[1], 1'b1};
         s_nxt.status = 8'h00;
         s_nxt.status[`SXO_ST_DRDY] = 1'b1;
         s_nxt.status[`SXO_ST_DF]   = ev_r[3];
         s_nxt.run = sxo_pkg::SXO_IDLE;
         if (ev_r[1] || ev_r[2]) begin
            s_nxt.error = 8'h00;
            s_nxt.error[`SXO_ERR_ABRT] = ev_r[1];
            s_nxt.error[`SXO_ERR_IDNF] = ev_r[2];
            s_nxt.status[`SXO_ST_ERR]  = 1'b1;
            s_nxt.sig_lo = ev_r[1] ? `SXO_FAIL_LO : `SXO_KEY_LO;
            s_nxt.sig_hi = ev_r[1] ? `SXO_FAIL_HI : `SXO_KEY_HI;
         end else begin
            s_nxt.sig_lo = `SXO_KEY_LO;
            s_nxt.sig_hi = `SXO_KEY_HI;
         end
      end

      // Off-line routine end, result kept
      if (s_r.run == sxo_pkg::SXO_OFFLINE && (ev_r[0] || ev_r[1])) begin
         s_nxt.st_status = {6'h00, ev_r[1], 1'b1};
         s_nxt.run = sxo_pkg::SXO_IDLE;
      end

      // Serve an interrupting command
      if (s_r.status[`SXO_ST_BSY] && s_r.run != sxo_pkg::SXO_CAPTIVE) begin
         svc_cnt_nxt = svc_cnt_r + 32'h1;
         if (svc_cnt_r >= SERVICE_CYC - 1) begin
            s_nxt.status = 8'h00;
            s_nxt.status[`SXO_ST_DRDY] = 1'b1;
            svc_cnt_nxt = 32'h0;
         end
      end

      // Register write decode
      if (wr_fire) begin
         s_nxt.awv    = 1'b0;
         s_nxt.wv     = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp  = `SXO_AXI_OKAY;
         case (s_r.awaddr)
            `SXO_OFF_FEATURES: s_nxt.features = s_r.wdata[7:0];
            `SXO_OFF_SECCNT:   s_nxt.seccnt   = s_r.wdata[7:0];
            `SXO_OFF_SUBCMD:   s_nxt.subcmd   = s_r.wdata[7:0];
            `SXO_OFF_SIGLO:    s_nxt.sig_lo   = s_r.wdata[7:0];
            `SXO_OFF_SIGHI:    s_nxt.sig_hi   = s_r.wdata[7:0];
            `SXO_OFF_DRVSEL:   s_nxt.drvsel   = s_r.wdata[7:0];
            `SXO_OFF_CTRL: begin
               s_nxt.supported = s_r.wdata[`SXO_CTL_SUPPORTED];
               s_nxt.enabled   = s_r.wdata[`SXO_CTL_ENABLED];
            end
            `SXO_OFF_COMMAND: begin
               s_nxt.error  = 8'h00;
               s_nxt.status = 8'h00;
               s_nxt.status[`SXO_ST_DRDY] = 1'b1;
               if (is_smart && s_r.features == `SXO_FEAT_EXEC) begin
                  if (!s_r.supported || !s_r.enabled || !key_ok
                      || !sub_valid) begin
                     s_nxt.error[`SXO_ERR_ABRT] = 1'b1;
                     s_nxt.status[`SXO_ST_ERR]  = 1'b1;
                     // Captive codes keep the key; off-line left as is
                     if (sub_captive) begin
                        s_nxt.sig_lo = `SXO_KEY_LO;
                        s_nxt.sig_hi = `SXO_KEY_HI;
                     end
                  end else if (sub_captive) begin
                     s_nxt.status[`SXO_ST_BSY]  = 1'b1;
                     s_nxt.status[`SXO_ST_DRDY] = 1'b0;
                     s_nxt.routine = s_r.subcmd;
                     s_nxt.run = sxo_pkg::SXO_CAPTIVE;
                     s_nxt.stop_req = 1'b1;
                  end else if (s_r.subcmd == `SXO_SUB_ABORT) begin
                     if (s_r.routine != `SXO_SUB_COLLECT) begin
                        s_nxt.run = sxo_pkg::SXO_IDLE;
                        s_nxt.stop_req = 1'b1;
                     end
                  end else begin
                     // Completion posted now, routine starts after
                     s_nxt.routine = s_r.subcmd;
                     s_nxt.run = sxo_pkg::SXO_OFFLINE;
                     s_nxt.stop_req = 1'b1;
                     s_nxt.paused_pwr = 1'b0;
                  end
               end else if (is_smart
                            && s_r.features == `SXO_FEAT_DISABLE) begin
                  s_nxt.enabled = 1'b0;
                  if (s_r.run == sxo_pkg::SXO_OFFLINE) begin
                     s_nxt.run = sxo_pkg::SXO_SUSPEND;
                  end
               end else if (is_smart
                            && s_r.features == `SXO_FEAT_ENABLE) begin
                  s_nxt.enabled = 1'b1;
                  if (s_r.run == sxo_pkg::SXO_SUSPEND
                      && !s_r.paused_pwr) begin
                     s_nxt.run = sxo_pkg::SXO_OFFLINE;
                  end
               end else if (cmd_code == `SXO_CMD_SLEEP) begin
                  // Self-test aborted; collection aborted too
                  if (s_r.run == sxo_pkg::SXO_OFFLINE) begin
                     s_nxt.run = sxo_pkg::SXO_IDLE;
                  end
               end else if (cmd_code == `SXO_CMD_STBY_IMM
                            || cmd_code == `SXO_CMD_IDLE_IMM) begin
                  if (s_r.run == sxo_pkg::SXO_OFFLINE) begin
                     s_nxt.run = sxo_pkg::SXO_SUSPEND;
                     s_nxt.paused_pwr = 1'b1;
                  end
               end else begin
                  // Exit from power save resumes a paused routine
                  if (s_r.run == sxo_pkg::SXO_SUSPEND && s_r.paused_pwr
                      && s_r.enabled) begin
                     s_nxt.run = sxo_pkg::SXO_OFFLINE;
                     s_nxt.paused_pwr = 1'b0;
                  end
                  // Other commands take BSY until served while an off-line routine runs
                  if (s_r.run == sxo_pkg::SXO_OFFLINE) begin
                     s_nxt.status[`SXO_ST_BSY]  = 1'b1;
                     s_nxt.status[`SXO_ST_DRDY] = 1'b0;
                  end
               end
            end
            // Read-only and unmapped offsets refuse writes
            default: s_nxt.bresp = `SXO_AXI_SLVERR;
         endcase
      end

      // Read channel: one read at a time
      s_nxt.arready = !s_r.rvalid && !rd_fire;
      if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
      end
      if (rd_fire) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp  = `SXO_AXI_OKAY;
         s_nxt.rdata  = 32'h0;
         case (s_axi_araddr)
            `SXO_OFF_FEATURES: s_nxt.rdata[7:0] = s_r.features;
            `SXO_OFF_SECCNT:   s_nxt.rdata[7:0] = s_r.seccnt;
            `SXO_OFF_SUBCMD:   s_nxt.rdata[7:0] = s_r.subcmd;
            `SXO_OFF_SIGLO:    s_nxt.rdata[7:0] = s_r.sig_lo;
            `SXO_OFF_SIGHI:    s_nxt.rdata[7:0] = s_r.sig_hi;
            `SXO_OFF_DRVSEL:   s_nxt.rdata[7:0] = s_r.drvsel;
            `SXO_OFF_COMMAND:  s_nxt.rdata[7:0] = s_r.status;
            `SXO_OFF_ERROR:    s_nxt.rdata[7:0] = s_r.error;
            `SXO_OFF_STATE:    s_nxt.rdata[7:0] = s_r.status;
            `SXO_OFF_CTRL:     s_nxt.rdata[3:0] =
               {s_r.run, s_r.enabled, s_r.supported};
            `SXO_OFF_RESULT:   s_nxt.rdata[7:0] = s_r.st_status;
            default:           s_nxt.rresp = `SXO_AXI_SLVERR;
         endcase
      end
   end

   // State register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '0;
         s_r.status[`SXO_ST_DRDY] <= 1'b1;
         s_r.arready <= 1'b1;
         svc_cnt_r <= 32'h0;
      end else begin
         s_r <= s_nxt;
         svc_cnt_r <= svc_cnt_nxt;
      end
   end

   // Outputs straight from flip-flops
   assign s_axi_awready = !s_r.awv;
   assign s_axi_wready  = !s_r.wv;
   assign s_axi_bvalid  = s_r.bvalid;
   assign s_axi_bresp   = s_r.bresp;
   assign s_axi_arready = s_r.arready;
   assign s_axi_rvalid  = s_r.rvalid;
   assign s_axi_rdata   = s_r.rdata;
   assign s_axi_rresp   = s_r.rresp;
   // Stop pulse lets the engine restart on a new subcommand
   assign routine_run   = !s_r.stop_req
                          && (s_r.run == sxo_pkg::SXO_OFFLINE
                              || s_r.run == sxo_pkg::SXO_CAPTIVE);
   assign routine_sel   = s_r.routine;
   assign cmd_pending   = s_r.status[`SXO_ST_BSY]
                          && s_r.run != sxo_pkg::SXO_CAPTIVE;
   // Standby timer held off while any routine is live
   assign standby_hold  = s_r.run != sxo_pkg::SXO_IDLE;

endmodule : sxo_exec
`default_nettype wire

// ### sxo_exec_props.sv
// Checker for the interpreter's bus and routine engine ports
`timescale 1ns/1ps
`default_nettype none
module sxo_exec_props #(
   parameter int unsigned SERVICE_CYC = 8
) (
   input wire logic        aclk,          // Clock
   input wire logic        aresetn,       // Reset, low
   input wire logic        s_axi_awvalid, // AW valid
   input wire logic        s_axi_awready, // AW ready
   input wire logic        s_axi_wvalid,  // W valid
   input wire logic        s_axi_wready,  // W ready
   input wire logic [1:0]  s_axi_bresp,   // B resp
   input wire logic        s_axi_bvalid,  // B valid
   input wire logic        s_axi_bready,  // B ready
   input wire logic        s_axi_arvalid, // AR valid
   input wire logic        s_axi_arready, // AR ready
   input wire logic [31:0] s_axi_rdata,   // R data
   input wire logic        s_axi_rvalid,  // R valid
   input wire logic        s_axi_rready,  // R ready
   input wire logic        routine_done,  // Engine done
   input wire logic        routine_run,   // Engine may run
   input wire logic [7:0]  routine_sel,   // Subcommand
   input wire logic        cmd_pending,   // Being served
   input wire logic        standby_hold   // Standby blocked
);
   // Margin for the two-flop sync
   localparam int SVC_LIM = SERVICE_CYC + 4;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Bus handshake timing
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("late write response");
   a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("late read data");
   a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken early");
   a_upper_zero: assert property (s_axi_rvalid |->
      s_axi_rdata[31:8] == 24'h000000) else $error("upper read bits set");
   // Routine engine control
   a_sel_legal: assert property (routine_run |-> routine_sel inside {8'h00,
      8'h01, 8'h02, 8'h81, 8'h82}) else $error("engine runs bad subcommand");
   a_no_standby: assert property (routine_run |-> standby_hold)
      else $error("standby not held");
   a_captive_end: assert property (routine_run && routine_done &&
      routine_sel[7] |-> ##[1:8] !routine_run)
      else $error("captive routine not ended");
   a_service_bound: assert property ($rose(cmd_pending) |->
      ##[1:SVC_LIM] !cmd_pending) else $error("command service too slow");
endmodule : sxo_exec_props
bind sxo_exec sxo_exec_props #(.SERVICE_CYC(SERVICE_CYC)) chk_u (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .routine_done(routine_done),
   .routine_run(routine_run), .routine_sel(routine_sel),
   .cmd_pending(cmd_pending), .standby_hold(standby_hold));
`default_nettype wire

// ### sxo_pkg.sv
// Types for the off-line/self-test command interpreter
package sxo_pkg;
   typedef enum logic [1:0] {
      SXO_IDLE    = 2'b00,
      SXO_OFFLINE = 2'b01,
      SXO_CAPTIVE = 2'b11,
      SXO_SUSPEND = 2'b10
   } sxo_run_t;

   typedef struct packed {
      logic [7:0] features;
      logic [7:0] seccnt;
      logic [7:0] subcmd;
      logic [7:0] sig_lo;
      logic [7:0] sig_hi;
      logic [7:0] drvsel;
      logic [7:0] error;
      logic [7:0] status;
      logic       supported;
      logic       enabled;
      sxo_run_t   run;
      logic [7:0] routine;
      logic       paused_pwr;
      logic       selftest_fail;
      logic [7:0] st_status;
      logic       awv;
      logic [7:0] awaddr;
      logic       wv;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic       bvalid;
      logic [1:0] bresp;
      logic       arready;
      logic       rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic       stop_req;
   } sxo_state_t;
endpackage : sxo_pkg

// ### tb.sv
// Self-checking bench for the off-line/self-test interpreter
`timescale 1ns/1ps
`default_nettype none
`include "sxo_defines.svh"
module tb;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0]  awaddr, araddr, sel;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic        awready, wready, bvalid, arready, rvalid, fail_mode;
   logic [1:0]  bresp, rresp;
   logic        done, fail, idnf, fault, run, pend, hold;
   int          num_errors = 0, checked = 0, cyc = 0;
   sxo_exec #(.SERVICE_CYC(8)) dut_u (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .routine_done(done),
      .routine_fail(fail), .idnf_event(idnf), .fault_event(fault),
      .routine_run(run), .routine_sel(sel), .cmd_pending(pend),
      .standby_hold(hold));
   sxo_engine_model eng_u (.aclk(aclk), .aresetn(aresetn),
      .routine_run(run), .routine_sel(sel), .fail_mode(fail_mode),
      .routine_done(done), .routine_fail(fail), .idnf_event(idnf),
      .fault_event(fault));
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   task automatic give_verdict;
      if (num_errors == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : give_verdict
   task automatic chk(input string what, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // AW and W offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      @(posedge aclk);
      awaddr <= a; wdata <= d; wstrb <= 4'hF;
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata; r = rresp;
      rready <= 1'b0;
   endtask : rd
   task automatic rchk(input string what, input logic [7:0] a,
                       input logic [31:0] exp);
      logic [31:0] d; logic [1:0] r;
      rd(a, d, r);
      chk(what, d, exp);
   endtask : rchk
   // Host loads key and device select, then the command code
   task automatic issue(input logic [7:0] f, sub, cmd, lo = 8'h4F);
      logic [1:0] r;
      wr(`SXO_OFF_FEATURES, f, r);
      wr(`SXO_OFF_SIGLO, lo, r);
      wr(`SXO_OFF_SIGHI, 8'hC2, r);
      wr(`SXO_OFF_SUBCMD, sub, r);
      wr(`SXO_OFF_DRVSEL, 8'h10, r);
      wr(`SXO_OFF_COMMAND, cmd, r);
   endtask : issue
   task automatic wait_idle;
      logic [31:0] s; logic [1:0] r;
      for (int i = 0; i < 200; i++) begin
         rd(`SXO_OFF_COMMAND, s, r);
         if (s[7] === 1'b0) break;
      end
   endtask : wait_idle
   task automatic run_state(input logic [1:0] exp);
      logic [31:0] d; logic [1:0] r;
      rd(`SXO_OFF_CTRL, d, r);
      chk("run state", d[3:2], exp);
   endtask : run_state
   task automatic step(input logic [7:0] f, cmd, input logic [1:0] exp);
      issue(f, 8'h00, cmd);
      wait_idle();
      run_state(exp);
   endtask : step
   task automatic t_reset;
      logic [31:0] d; logic [1:0] r;
      rchk("reset status", `SXO_OFF_COMMAND, 32'h40);
      rchk("reset ctrl", `SXO_OFF_CTRL, 32'h0);
      rd(8'h30, d, r);
      chk("unmapped resp", r, `SXO_AXI_SLVERR);
      wr(`SXO_OFF_ERROR, 32'h1, r);
      chk("read-only resp", r, `SXO_AXI_SLVERR);
   endtask : t_reset
   // Rows: control, key low, subcommand; all abort
   task automatic t_refuse;
      logic [23:0] tv [7] = '{24'h014F81, 24'h030082, 24'h024F01,
         24'h034F03, 24'h034F80, 24'h034F40, 24'h034FC0};
      logic [1:0] r;
      for (int i = 0; i < 7; i++) begin
         wr(`SXO_OFF_CTRL, tv[i][23:16], r);
         issue(8'hD4, tv[i][7:0], 8'hB0, tv[i][15:8]);
         wait_idle();
         rchk("abort error", `SXO_OFF_ERROR, 32'h04);
         rchk("abort status", `SXO_OFF_COMMAND, 32'h41);
         rchk("abort dev", `SXO_OFF_DRVSEL, 32'h10);
         if (i < 2) rchk("key low", `SXO_OFF_SIGLO, 32'h4F);
         if (i < 2) rchk("key high", `SXO_OFF_SIGHI, 32'hC2);
      end
   endtask : t_refuse
   task automatic t_captive;
      logic [31:0] s; logic [1:0] r;
      wr(`SXO_OFF_CTRL, 32'h3, r);
      fail_mode <= 1'b0;
      issue(8'hD4, 8'h81, 8'hB0);
      rd(`SXO_OFF_COMMAND, s, r);
      chk("captive busy", s[7], 1'b1);
      chk("captive sel", sel, 8'h81);
      wait_idle();
      rchk("pass error", `SXO_OFF_ERROR, 32'h00);
      rchk("pass status", `SXO_OFF_COMMAND, 32'h40);
      rchk("pass low", `SXO_OFF_SIGLO, 32'h4F);
      rchk("pass high", `SXO_OFF_SIGHI, 32'hC2);
      rchk("pass result", `SXO_OFF_RESULT, 32'h01);
      fail_mode <= 1'b1;
      issue(8'hD4, 8'h82, 8'hB0);
      chk("extended sel", sel, 8'h82);
      wait_idle();
      rchk("fail error", `SXO_OFF_ERROR, 32'h14);
      rchk("fail status", `SXO_OFF_COMMAND, 32'h61);
      rchk("fail low", `SXO_OFF_SIGLO, 32'hF4);
      rchk("fail high", `SXO_OFF_SIGHI, 32'h2C);
      rchk("fail result", `SXO_OFF_RESULT, 32'h03);
      fail_mode <= 1'b0;
   endtask : t_captive
   task automatic t_offline;
      logic [31:0] s; logic [1:0] r;
      issue(8'hD4, 8'h01, 8'hB0);
      rchk("offline status", `SXO_OFF_COMMAND, 32'h40);
      chk("offline run", {run, hold, sel}, 10'h301);
      run_state(2'b01);
      issue(8'hD4, 8'h02, 8'hB0);
      repeat (4) @(posedge aclk);
      chk("restart sel", {run, sel}, 9'h102);
      rchk("still ready", `SXO_OFF_COMMAND, 32'h40);
      issue(8'hD4, 8'h7F, 8'hB0);
      repeat (4) @(posedge aclk);
      chk("aborted run", run, 1'b0);
      run_state(2'b00);
      issue(8'hD4, 8'h00, 8'hB0);
      repeat (2) @(posedge aclk);
      chk("collect sel", {run, sel}, 9'h100);
      issue(8'h00, 8'h00, 8'hEC);
      rd(`SXO_OFF_COMMAND, s, r);
      chk("serve busy", s[7], 1'b1);
      wait_idle();
      rchk("served", `SXO_OFF_COMMAND, 32'h40);
      step(8'hD9, 8'hB0, 2'b10);
      step(8'hD8, 8'hB0, 2'b01);
      step(8'h00, 8'hE0, 2'b10);
      step(8'h00, 8'hEC, 2'b01);
      issue(8'hD4, 8'h01, 8'hB0);
      step(8'h00, 8'hE6, 2'b00);
      chk("sleep run", run, 1'b0);
   endtask : t_offline
   // Hang guard, far above the run's length
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         num_errors++;
         give_verdict();
      end
   end
   initial begin
      aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
      arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00;
      wdata = 32'h0; wstrb = 4'h0; fail_mode = 1'b0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_refuse();
      t_captive();
      t_offline();
      give_verdict();
   end
endmodule : tb
`default_nettype wire
